// ### hw/pprd_pkg.sv
// Package with register map and constants for the port pin and reset block
// Overview of operation
// - Reset pin active low, bidirectional, drives internal resets
// - Mode pin latched at reset release, pulled up
// - Nine analog pins: direction, wake-up, pull select
// - Analog, P, T pulls disabled during/after reset
// - Two E pins, pull-down only, enabled after reset
// - Three P pins: direction, wake-up, pull select
// - Six S pins, wake-up, pulls up by reset
// - Four T pins, pull select, no wake-up
package pprd_pkg;
  localparam int AD_W = 9;
  localparam int E_W  = 2;
  localparam int P_W  = 3;
  localparam int S_W  = 6;
  localparam int T_W  = 4;
  localparam int NPORT = 5;
  // Register byte offset inside a port block: byte addr = port*32 + offset
  localparam logic [7:0] ADR_DATA = 8'h00;
  localparam logic [7:0] ADR_DIR  = 8'h04;
  localparam logic [7:0] ADR_PEN  = 8'h08;
  localparam logic [7:0] ADR_PSEL = 8'h0C;
  localparam logic [7:0] ADR_WIEN = 8'h10;
  localparam logic [7:0] ADR_WFLG = 8'h14;
  localparam logic [7:0] ADR_IN   = 8'h18;
  localparam logic [7:0] ADR_MODE = 8'hA0;
  localparam logic [7:0] ADR_RST  = 8'hA4;
  localparam logic [2:0] PORT_AD = 3'h0;
  localparam logic [2:0] PORT_E  = 3'h1;
  localparam logic [2:0] PORT_P  = 3'h2;
  localparam logic [2:0] PORT_S  = 3'h3;
  localparam logic [2:0] PORT_T  = 3'h4;
  localparam logic [8:0] PEN_RST_AD = 9'h000;
  localparam logic [8:0] PEN_RST_E  = 9'h003;
  localparam logic [8:0] PEN_RST_P  = 9'h000;
  localparam logic [8:0] PEN_RST_S  = 9'h03F;
  localparam logic [8:0] PEN_RST_T  = 9'h000;
  // Pull select reset: 1 = pull-up; E port is pull-down only
  localparam logic [8:0] PSEL_RST_S = 9'h03F;
  localparam logic [8:0] ZERO9 = 9'h000;
  // Minimum length of a software-requested reset pulse on the pin
  localparam real RST_PULSE_NS = 1000.0;
  localparam real CLK_NS = 8.0;
  localparam int  RST_PULSE_CYC = int'($ceil(RST_PULSE_NS / CLK_NS));
  localparam logic [31:0] RST_KEY = 32'h0000_00A5;
endpackage : pprd_pkg

// ### hw/pprd_top.sv
// Port pin, pull default, wake-up flag, reset pin and mode latch logic
`timescale 1ns/1ns
`default_nettype none
module pprd_top
  import pprd_pkg::*;
#(
  parameter int RST_CYC = pprd_pkg::RST_PULSE_CYC
)(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Reset pin, active low, two-way
  input  wire logic                 reset_pin_n_i,
  output logic                      reset_pin_n_o,
  output logic                      reset_pin_n_oe,
  input  wire logic                 internal_rst_req,
  output logic                      device_rst,
  // Mode select
  input  wire logic                 mode_select_input,
  output logic                      mode_select_pullup,
  output logic                      mode_bit,
  // Port pins, flat: AD[8:0], E[1:0], P[2:0], S[5:0], T[3:0]
  input  wire logic [AD_W-1:0]      analog_port_pins_i,
  input  wire logic [E_W-1:0]       e_port_pins_i,
  input  wire logic [P_W-1:0]       p_port_pins_i,
  input  wire logic [S_W-1:0]       s_port_pins_i,
  input  wire logic [T_W-1:0]       t_port_pins_i,
  output logic      [NPORT*9-1:0]   pin_out,
  output logic      [NPORT*9-1:0]   pin_oe,
  output logic      [NPORT*9-1:0]   pull_up_en,
  output logic      [NPORT*9-1:0]   pull_dn_en,
  // Wake-up interrupts
  output logic                      analog_port_wakeup_irq,
  output logic                      p_port_wakeup_irq,
  output logic                      s_port_wakeup_irq
);
  import pprd_pkg::*;

  initial
  begin
    if (RST_CYC < 1 || RST_CYC > 65535)
      $error("RST_CYC out of range");
  end

  localparam logic [8:0] WMASK [NPORT] = '{9'h1FF, 9'h003, 9'h007, 9'h03F, 9'h00F};
  // Ports that have wake-up (AD, P, S)
  localparam logic [NPORT-1:0] HAS_WAKE = 5'b01101;
  localparam logic [8:0] PEN_RST [NPORT] = '{PEN_RST_AD, PEN_RST_E, PEN_RST_P,
                                             PEN_RST_S, PEN_RST_T};
  localparam logic [8:0] PSEL_RST [NPORT] = '{ZERO9, ZERO9, ZERO9, PSEL_RST_S, ZERO9};
  // S port pull-ups stay on while the device is held in reset
  localparam logic [44:0] PU_RST = 45'(PEN_RST_S & PSEL_RST_S) << (9 * int'(PORT_S));

  function automatic logic [8:0] merge(input logic [8:0] old, input logic [31:0] d,
                                       input logic [3:0] sel);
    logic [8:0] r;
    r = old;
    if (sel[0])
      r[7:0] = d[7:0];
    if (sel[1])
      r[8] = d[8];
    return r;
  endfunction : merge

  logic [8:0] pin_in [NPORT];
  assign pin_in[0] = analog_port_pins_i;
  assign pin_in[1] = {7'h00, e_port_pins_i};
  assign pin_in[2] = {6'h00, p_port_pins_i};
  assign pin_in[3] = {3'h0, s_port_pins_i};
  assign pin_in[4] = {5'h00, t_port_pins_i};

  logic [8:0] data_reg [NPORT], data_next [NPORT];
  logic [8:0] dir_reg [NPORT], dir_next [NPORT];
  logic [8:0] pen_reg [NPORT], pen_next [NPORT];
  logic [8:0] psel_reg [NPORT], psel_next [NPORT];
  logic [8:0] wien_reg [NPORT], wien_next [NPORT];
  logic [8:0] wflg_reg [NPORT], wflg_next [NPORT];
  logic [8:0] in_reg [NPORT], in_next [NPORT];
  logic       ack_reg, ack_next;
  logic [31:0] rd_reg, rd_next;
  logic [2:0] irq_reg, irq_next;
  logic [44:0] out_reg, oe_reg, pu_reg, pd_reg;
  logic [44:0] out_next, oe_next, pu_next, pd_next;

  wire logic       wb_req  = wb_cyc_i && wb_stb_i && !ack_reg;
  wire logic       wb_wr   = wb_req && wb_we_i;
  wire logic [2:0] wb_port = wb_adr_i[7:5];
  wire logic [7:0] wb_reg  = {3'h0, wb_adr_i[4:0]};

  // Reset pin and mode latch state
  logic        pin_d_reg, pin_d_next;
  logic        drive_reg, drive_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        mode_reg, mode_next;
  logic        sw_rst_reg, sw_rst_next;
  logic        dev_rst_reg, dev_rst_next;

  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      data_next[p] = data_reg[p];
      dir_next[p]  = dir_reg[p];
      pen_next[p]  = pen_reg[p];
      psel_next[p] = psel_reg[p];
      wien_next[p] = wien_reg[p];
      in_next[p]   = pin_in[p] & WMASK[p];
      wflg_next[p] = wflg_reg[p];
      if (wb_wr && wb_port == 3'(p))
      begin
        case (wb_reg)
          ADR_DATA: data_next[p] = merge(data_reg[p], wb_dat_i, wb_sel_i) & WMASK[p];
          ADR_DIR:  dir_next[p]  = merge(dir_reg[p], wb_dat_i, wb_sel_i) & WMASK[p];
          ADR_PEN:  pen_next[p]  = merge(pen_reg[p], wb_dat_i, wb_sel_i) & WMASK[p];
          // E port has a pull-down only
          ADR_PSEL: psel_next[p] = (p == 1) ? ZERO9 :
                                   merge(psel_reg[p], wb_dat_i, wb_sel_i) & WMASK[p];
          ADR_WIEN: wien_next[p] = HAS_WAKE[p] ?
                                   merge(wien_reg[p], wb_dat_i, wb_sel_i) & WMASK[p]
                                   : ZERO9;
          ADR_WFLG: wflg_next[p] = wflg_reg[p] & ~merge(ZERO9, wb_dat_i, wb_sel_i);
          default: ;
        endcase
      end
      // Falling edge on an enabled input pin; set wins over clear
      wflg_next[p] = wflg_next[p] | (in_reg[p] & ~in_next[p] & wien_reg[p] & ~dir_reg[p]);
    end
    for (int p = 0; p < NPORT; p++)
    begin
      for (int b = 0; b < 9; b++)
      begin
        out_next[p*9+b] = data_reg[p][b];
        oe_next[p*9+b]  = dir_reg[p][b];
        pu_next[p*9+b]  = pen_reg[p][b] && psel_reg[p][b] && !dir_reg[p][b];
        pd_next[p*9+b]  = pen_reg[p][b] && !psel_reg[p][b] && !dir_reg[p][b];
      end
    end
    irq_next = {|wflg_reg[3], |wflg_reg[2], |wflg_reg[0]};
    ack_next = wb_req;
    rd_next  = 32'h0000_0000;
    if (wb_req && !wb_we_i)
    begin
      if (wb_adr_i == ADR_MODE)
        rd_next = {31'h0, mode_reg};
      else if (wb_adr_i == ADR_RST)
        rd_next = {31'h0, drive_reg};
      else if (wb_port < 3'(NPORT))
      begin
        case (wb_reg)
          ADR_DATA: rd_next = {23'h0, data_reg[wb_port]};
          ADR_DIR:  rd_next = {23'h0, dir_reg[wb_port]};
          ADR_PEN:  rd_next = {23'h0, pen_reg[wb_port]};
          ADR_PSEL: rd_next = {23'h0, psel_reg[wb_port]};
          ADR_WIEN: rd_next = {23'h0, wien_reg[wb_port]};
          ADR_WFLG: rd_next = {23'h0, wflg_reg[wb_port]};
          ADR_IN:   rd_next = {23'h0, in_reg[wb_port]};
          default:  rd_next = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || dev_rst_reg)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        data_reg[p] <= ZERO9;
        dir_reg[p]  <= ZERO9;
        pen_reg[p]  <= PEN_RST[p];
        psel_reg[p] <= PSEL_RST[p];
        wien_reg[p] <= ZERO9;
        wflg_reg[p] <= ZERO9;
        in_reg[p]   <= ZERO9;
      end
      ack_reg <= 1'b0;
      rd_reg  <= 32'h0000_0000;
      irq_reg <= 3'h0;
      out_reg <= '0;
      oe_reg  <= '0;
      pu_reg  <= PU_RST;
      pd_reg  <= '0;
    end
    else
    begin
      data_reg <= data_next;
      dir_reg  <= dir_next;
      pen_reg  <= pen_next;
      psel_reg <= psel_next;
      wien_reg <= wien_next;
      wflg_reg <= wflg_next;
      in_reg   <= in_next;
      ack_reg  <= ack_next;
      rd_reg   <= rd_next;
      irq_reg  <= irq_next;
      out_reg  <= out_next;
      oe_reg   <= oe_next;
      pu_reg   <= pu_next;
      pd_reg   <= pd_next;
    end
  end

  // Reset pin: drive low for internal requests, latch mode on release
  always_comb
  begin
    pin_d_next   = reset_pin_n_i;
    sw_rst_next  = wb_wr && wb_adr_i == ADR_RST && wb_dat_i == RST_KEY;
    drive_next   = drive_reg;
    cnt_next     = cnt_reg;
    if (internal_rst_req || sw_rst_reg)
    begin
      drive_next = 1'b1;
      cnt_next   = 16'(RST_CYC);
    end
    else if (cnt_reg > 16'h0001)
      cnt_next = cnt_reg - 16'h0001;
    else
    begin
      drive_next = 1'b0;
      cnt_next   = 16'h0000;
    end
    dev_rst_next = !reset_pin_n_i || drive_next;
    mode_next    = mode_reg;
    if (!pin_d_reg && reset_pin_n_i)
      mode_next = mode_select_input;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pin_d_reg   <= 1'b0;
      drive_reg   <= 1'b0;
      cnt_reg     <= 16'h0000;
      mode_reg    <= 1'b1;
      sw_rst_reg  <= 1'b0;
      dev_rst_reg <= 1'b1;
    end
    else
    begin
      pin_d_reg   <= pin_d_next;
      drive_reg   <= drive_next;
      cnt_reg     <= cnt_next;
      mode_reg    <= mode_next;
      sw_rst_reg  <= sw_rst_next;
      dev_rst_reg <= dev_rst_next;
    end
  end

  assign wb_dat_o               = rd_reg;
  assign wb_ack_o               = ack_reg;
  assign reset_pin_n_o          = 1'b0;
  assign reset_pin_n_oe         = drive_reg;
  assign device_rst             = dev_rst_reg;
  assign mode_select_pullup     = 1'b1;
  assign mode_bit               = mode_reg;
  assign pin_out                = out_reg;
  assign pin_oe                 = oe_reg;
  assign pull_up_en             = pu_reg;
  assign pull_dn_en             = pd_reg;
  assign analog_port_wakeup_irq = irq_reg[0];
  assign p_port_wakeup_irq      = irq_reg[1];
  assign s_port_wakeup_irq      = irq_reg[2];

  chk_wb_ack_once: assert property (@(posedge sys_clk) disable iff (reset)
    ack_reg |=> !ack_reg) else $error("ack held two cycles");
  chk_pin_drive_req: assert property (@(posedge sys_clk) disable iff (reset)
    internal_rst_req |=> reset_pin_n_oe) else $error("reset pin not driven");
  chk_pin_low_reset: assert property (@(posedge sys_clk) disable iff (reset)
    !reset_pin_n_i |=> device_rst) else $error("pin low without reset");
  chk_mode_latch: assert property (@(posedge sys_clk) disable iff (reset)
    (!pin_d_reg && reset_pin_n_i) |=> mode_bit == $past(mode_select_input))
    else $error("mode not latched");
  chk_mode_hold: assert property (@(posedge sys_clk) disable iff (reset)
    (pin_d_reg && reset_pin_n_i) |=> $stable(mode_bit)) else $error("mode changed");
  chk_pull_default: assert property (@(posedge sys_clk)
    $past(reset) |-> pull_up_en == PU_RST && pull_dn_en == '0)
    else $error("pulls wrong in reset");
  chk_pen_defaults: assert property (@(posedge sys_clk)
    $past(reset) |-> pen_reg[0] == ZERO9 && pen_reg[2] == ZERO9 && pen_reg[4] == ZERO9)
    else $error("pull enable default wrong");
  chk_e_pulldown: assert property (@(posedge sys_clk)
    $past(reset) |-> pen_reg[1] == PEN_RST_E && psel_reg[1] == ZERO9)
    else $error("E pull-down default wrong");
  chk_s_pullup: assert property (@(posedge sys_clk)
    $past(reset) |-> pen_reg[3] == PEN_RST_S && psel_reg[3] == PSEL_RST_S)
    else $error("S pull-up default wrong");
  chk_t_nowake: assert property (@(posedge sys_clk) disable iff (reset)
    wien_reg[4] == ZERO9 && wflg_reg[4] == ZERO9) else $error("T wake-up set");
  chk_wake_set: assert property (@(posedge sys_clk) disable iff (reset || dev_rst_reg)
    (in_reg[3][0] && !in_next[3][0] && wien_reg[3][0] && !dir_reg[3][0])
    |=> wflg_reg[3][0] ##1 s_port_wakeup_irq) else $error("wake flag lost");
  chk_dir_write: assert property (@(posedge sys_clk) disable iff (reset || dev_rst_reg)
    (wb_wr && wb_adr_i == 8'h44 && wb_sel_i[0]) |=> dir_reg[2] == ($past(wb_dat_i[8:0]) & 9'h007))
    else $error("dir write lost");
  chk_ad_wake: assert property (@(posedge sys_clk) disable iff (reset || dev_rst_reg)
    (|wflg_reg[0]) |=> analog_port_wakeup_irq) else $error("AD irq missing");

  cov_wb_read: cover property (@(posedge sys_clk) wb_req && !wb_we_i ##1 ack_reg);
  cov_wake: cover property (@(posedge sys_clk) p_port_wakeup_irq);
  cov_int_rst: cover property (@(posedge sys_clk) internal_rst_req ##1 reset_pin_n_oe);
  cov_mode: cover property (@(posedge sys_clk) !pin_d_reg && reset_pin_n_i);
endmodule : pprd_top
`default_nettype wire

// ### test/pprd_board.sv
// Board model: pin drivers and pulls, reset switch and mode strap
`timescale 1ns/1ns
`default_nettype none
module pprd_board (
  // Clock
  input  wire logic        sys_clk,
  // Device side of the pins
  input  wire logic [44:0] pin_out,
  input  wire logic [44:0] pin_oe,
  input  wire logic [44:0] pull_up_en,
  input  wire logic [44:0] pull_dn_en,
  input  wire logic        rst_oe,
  // Board drivers
  input  wire logic [44:0] ext_val,
  input  wire logic [44:0] ext_en,
  input  wire logic        ext_rst_n,
  input  wire logic        mode_en,
  input  wire logic        mode_val,
  // Resolved levels
  output logic      [44:0] level,
  output logic             rst_level,
  output logic             mode_level
);
  logic [44:0] float_reg = 45'h0;
  logic [44:0] float_next;
  // Undriven, unpulled pins wander instead of holding a value
  always_comb float_next = ~float_reg;
  always_ff @(posedge sys_clk) float_reg <= float_next;
  always_comb
  begin
    for (int i = 0; i < 45; i++)
      level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                 pull_up_en[i] ? 1'b1 : pull_dn_en[i] ? 1'b0 : float_reg[i];
  end
  // Open-drain line with pull-up; either side may pull it low
  assign rst_level = ext_rst_n & ~rst_oe;
  // Strap reads high when the board leaves it open
  assign mode_level = mode_en ? mode_val : 1'b1;
endmodule : pprd_board
`default_nettype wire

// ### test/port_pins_reset_defaults_test.sv
// Self-checking bench for the port pin and reset block
`timescale 1ns/1ns
`default_nettype none
module port_pins_reset_defaults_test;
  import pprd_pkg::*;
  localparam int RC = 4;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, q;
  logic        wb_ack_o, rst_oe, device_rst, mode_bit, mode_select_pullup, rst_lvl, mode_lvl;
  logic        analog_port_wakeup_irq, p_port_wakeup_irq, s_port_wakeup_irq;
  logic        internal_rst_req = 1'b0;
  logic        ext_rst_n = 1'b1;
  logic        mode_en = 1'b0;
  logic        mode_val = 1'b1;
  logic [44:0] pin_out, pin_oe, pull_up_en, pull_dn_en, lvl;
  logic [44:0] ext_val = 45'h0;
  logic [44:0] ext_en = '1;
  logic [8:0]  dir_m [5], pen_m [5], psel_m [5];
  int          wd [5] = '{9, 2, 3, 6, 4};
  int          mismatches = 0;
  int          n_checks = 0;
  int          b, cnt;
  always #4 sys_clk = ~sys_clk;
  pprd_top #(.RST_CYC(RC)) DUT (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_pin_n_i(rst_lvl),
    .reset_pin_n_o(), .reset_pin_n_oe(rst_oe), .internal_rst_req, .device_rst,
    .mode_select_input(mode_lvl), .mode_select_pullup, .mode_bit,
    .analog_port_pins_i(lvl[8:0]), .e_port_pins_i(lvl[10:9]), .p_port_pins_i(lvl[20:18]),
    .s_port_pins_i(lvl[32:27]), .t_port_pins_i(lvl[39:36]), .pin_out, .pin_oe,
    .pull_up_en, .pull_dn_en, .analog_port_wakeup_irq, .p_port_wakeup_irq,
    .s_port_wakeup_irq);
  pprd_board BRD (.sys_clk, .pin_out, .pin_oe, .pull_up_en, .pull_dn_en, .rst_oe,
    .ext_val, .ext_en, .ext_rst_n, .mode_en, .mode_val, .level(lvl),
    .rst_level(rst_lvl), .mode_level(mode_lvl));
  function automatic logic [8:0] mk(int p);
    return 9'((1 << wd[p]) - 1);
  endfunction : mk
  function automatic logic [7:0] pa(int p, logic [7:0] off);
    return 8'(p * 32) + off;
  endfunction : pa
  // Kind 0: output enables, 1: pull-ups, 2: pull-downs
  function automatic logic [44:0] ex(int k);
    logic [44:0] r;
    r = '0;
    for (int p = 0; p < 5; p++)
      r[p*9 +: 9] = (k == 0) ? dir_m[p] :
                    pen_m[p] & ~dir_m[p] & ((k == 1) ? psel_m[p] : ~psel_m[p]);
    return r;
  endfunction : ex
  function automatic logic irq(int p);
    return (p == 0) ? analog_port_wakeup_irq : (p == 2) ? p_port_wakeup_irq : s_port_wakeup_irq;
  endfunction : irq
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [44:0] seen, input logic [44:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Classic single Wishbone cycle, held until ack is seen at a rising edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 40);
    if (wb_ack_o !== 1'b1)
    begin
      mismatches++;
      summarize();
    end
    if (!we)
      q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, 45'(q), 45'(exp));
  endtask : rdc
  task automatic hold(input int which, input logic v);
    int i;
    for (i = 0; i < 60 && ((which == 0) ? device_rst : rst_oe) !== v; i++)
      @(negedge sys_clk);
    if (i == 60)
    begin
      mismatches++;
      summarize();
    end
  endtask : hold
  task automatic mreset();
    dir_m  = '{default: ZERO9};
    pen_m  = '{PEN_RST_AD, PEN_RST_E, PEN_RST_P, PEN_RST_S, PEN_RST_T};
    psel_m = '{ZERO9, ZERO9, ZERO9, PSEL_RST_S, ZERO9};
  endtask : mreset
  initial
  begin
    void'($urandom(32'h0bc9_8dfb));
    mreset();
    ext_val <= 45'({$urandom, $urandom});
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("dev_rst", device_rst, 1'b1);
    chk("mode_bit", mode_bit, 1'b1);
    chk("mode_pu", mode_select_pullup, 1'b1);
    chk("pu_in_rst", pull_up_en, 45'(PEN_RST_S & PSEL_RST_S) << 27);
    @(posedge sys_clk);
    reset <= 1'b0;
    hold(0, 1'b0);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pu_out", pull_up_en, ex(1));
    chk("pd_out", pull_dn_en, ex(2));
    for (int p = 0; p < 5; p++)
      rdc("pen_rst", pa(p, ADR_PEN), 32'(pen_m[p]));
    for (int k = 0; k < 3; k++)
      for (int p = 0; p < 5; p++)
      begin
        q = $urandom;
        bus(1'b1, pa(p, ADR_DIR), q);
        dir_m[p] = q[8:0] & mk(p);
        q = $urandom;
        bus(1'b1, pa(p, ADR_PEN), q);
        pen_m[p] = q[8:0] & mk(p);
        q = $urandom;
        bus(1'b1, pa(p, ADR_PSEL), q);
        psel_m[p] = (p == 1) ? ZERO9 : q[8:0] & mk(p);
        q = $urandom;
        bus(1'b1, pa(p, ADR_WIEN), q);
        rdc("wien", pa(p, ADR_WIEN), (p == 1 || p == 4) ? 0 : 32'(q[8:0] & mk(p)));
        rdc("dir", pa(p, ADR_DIR), 32'(dir_m[p]));
        rdc("psel", pa(p, ADR_PSEL), 32'(psel_m[p]));
      end
    bus(1'b1, 8'hc0, 32'hffff_ffff);
    rdc("unmapped", 8'hc0, 32'h0000_0000);
    @(negedge sys_clk);
    chk("oe", pin_oe, ex(0));
    chk("pu", pull_up_en, ex(1));
    chk("pd", pull_dn_en, ex(2));
    for (int p = 0; p < 5; p++)
    begin
      if (p == 1 || p == 4)
        continue;
      b = $urandom_range(wd[p] - 1, 0);
      bus(1'b1, pa(p, ADR_DIR), 32'h0000_0000);
      ext_val[p*9+b] <= 1'b1;
      bus(1'b1, pa(p, ADR_WIEN), 32'(1 << b));
      bus(1'b1, pa(p, ADR_WFLG), 32'h0000_01ff);
      rdc("flag_clr", pa(p, ADR_WFLG), 32'h0000_0000);
      @(posedge sys_clk);
      ext_val[p*9+b] <= 1'b0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("irq_set", irq(p), 1'b1);
      rdc("flag_set", pa(p, ADR_WFLG), 32'(1 << b));
      rdc("in_lvl", pa(p, ADR_IN), 32'(ext_val[p*9 +: 9] & mk(p)));
      bus(1'b1, pa(p, ADR_WFLG), 32'(1 << b));
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("irq_clr", irq(p), 1'b0);
    end
    @(posedge sys_clk);
    mode_en <= 1'b1;
    mode_val <= 1'b0;
    ext_rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pin_rst", device_rst, 1'b1);
    @(posedge sys_clk);
    ext_rst_n <= 1'b1;
    hold(0, 1'b0);
    chk("mode_lat0", mode_bit, 1'b0);
    rdc("mode_reg", ADR_MODE, 32'h0000_0000);
    mreset();
    rdc("pen_s", pa(3, ADR_PEN), 32'(PEN_RST_S));
    rdc("pen_ad", pa(0, ADR_PEN), 32'h0000_0000);
    mode_en <= 1'b0;
    bus(1'b1, ADR_RST, RST_KEY);
    hold(1, 1'b1);
    chk("pin_low", rst_lvl, 1'b0);
    chk("sw_rst", device_rst, 1'b1);
    hold(1, 1'b0);
    hold(0, 1'b0);
    chk("mode_lat1", mode_bit, 1'b1);
    @(posedge sys_clk);
    internal_rst_req <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("int_oe", rst_oe, 1'b1);
    chk("int_rst", device_rst, 1'b1);
    @(posedge sys_clk);
    internal_rst_req <= 1'b0;
    for (cnt = 0; cnt < 60 && rst_oe === 1'b1; cnt++)
      @(negedge sys_clk);
    chk("oe_len", 45'(cnt >= RC && cnt <= RC + 2), 45'h1);
    hold(0, 1'b0);
    summarize();
  end
endmodule : port_pins_reset_defaults_test
`default_nettype wire
